// File: dv/fls_flow_src.sv
`timescale 1ns/1ps

// ==========================================================
// flow meter model: analog level and pulse train
module fls_flow_src (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // wanted flow
    input wire logic [13:0] level_in,
    input wire logic [7:0] period_in,
    // meter pins
    output logic [13:0] analog_out,
    output logic pulse_out
);
    logic [7:0] cnt_ff;
    logic pulse_ff;

    // analog meter follows the wanted level at once
    assign analog_out = level_in;
    assign pulse_out = pulse_ff;

    // one-cycle pulse every period_in cycles, none when zero
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_ff <= 8'h00;
            pulse_ff <= 1'b0;
        end else if (period_in == 8'h00) begin
            cnt_ff <= 8'h00;
            pulse_ff <= 1'b0;
        end else begin
            cnt_ff <= (cnt_ff >= period_in - 8'h01) ? 8'h00 : cnt_ff + 8'h01;
            pulse_ff <= (cnt_ff == 8'h00);
        end
    end
endmodule

// File: dv/tb_fls_top.sv
`timescale 1ns/1ps

// ==========================================================
// bench for the flow limit supervisor
module tb_fls_top;
    import fls_pkg::*;
    logic clk_in, nrst_in, rd, wr, pulse;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, q;
    logic [3:0] be;
    logic [13:0] level, analog;
    logic [7:0] period;
    logic wreq, stop, irq;
    fls_side_sts_t hi, lo;
    logic [4:0] fl;
    int n_mismatch, samples_checked, cyc;

    // flags as one vector: stop, hi warn, hi err, lo warn, lo err
    assign fl = {stop, hi, lo};

    fls_top #(.TICK_CYCLES(20)) u_fls_top (.clk_in(clk_in),
        .nrst_in(nrst_in), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .analog_flow_input_in(analog),
        .pulse_flow_input_in(pulse), .stop_request_out(stop),
        .high_flow_out(hi), .low_flow_out(lo), .irq_out(irq));

    fls_flow_src u_fls_flow_src (.clk_in(clk_in), .nrst_in(nrst_in),
        .level_in(level), .period_in(period), .analog_out(analog),
        .pulse_out(pulse));

    // free running clock
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // hang guard
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk_in);
        end while (wreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk_in);
    endtask

    // wait a bounded time for a flag, then compare it
    task automatic wait_fl(input int i, input int lim);
        int n;
        n = 0;
        while (fl[i] !== 1'b1 && n < lim) begin
            @(posedge clk_in);
            n++;
        end
        chk({31'h0, fl[i]}, 32'h0000_0001);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // reset values and an unmapped place
    task automatic t_regs();
        bus(1'b0, 5'h04, 32'h0); chk(q, 32'h0000_26AC);
        bus(1'b0, 5'h08, 32'h0); chk(q, 32'h0000_0001);
        bus(1'b0, 5'h1C, 32'h0); chk(q, 32'h0000_0000);
    endtask

    // high side, warning then stop error, interrupt, clear
    task automatic t_high_err();
        level <= 14'h26D8;
        bus(1'b1, 5'h0C, 32'h0000_0101);
        bus(1'b1, 5'h00, 32'h0000_0009);
        wait_fl(3, 80);
        chk({31'h0, hi.err}, 32'h0);
        wait_fl(2, 80);
        idle(1);
        chk({31'h0, stop}, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 5'h18, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0001);
        bus(1'b1, 5'h14, 32'h0000_0003);
        chk({31'h0, irq}, 32'h0);
        level <= 14'h1388;
        bus(1'b1, 5'h00, 32'h0000_0109);
        idle(4);
        chk({27'h0, fl}, 32'h0);
    endtask

    // warning-only side, and restart of the warning timer
    task automatic t_high_warn();
        bus(1'b1, 5'h0C, 32'h0000_0103);
        bus(1'b1, 5'h00, 32'h0000_0005);
        level <= 14'h26D8;
        idle(40);
        level <= 14'h1388;
        idle(10);
        level <= 14'h26D8;
        idle(40);
        chk({31'h0, hi.warn}, 32'h0);
        wait_fl(3, 80);
        idle(120);
        chk({27'h0, fl}, 32'h0000_0008);
    endtask

    // low side: off, no source, warning only, pulse source with error
    task automatic t_low();
        level <= 14'h03E8;
        bus(1'b1, 5'h08, 32'h0000_07D0);
        bus(1'b1, 5'h0C, 32'h0101_0000);
        bus(1'b1, 5'h00, 32'h0000_0001);
        idle(100);
        chk({30'h0, lo}, 32'h0);
        bus(1'b1, 5'h00, 32'h0000_0020);
        idle(100);
        chk({30'h0, lo}, 32'h0);
        bus(1'b1, 5'h00, 32'h0000_0011);
        wait_fl(1, 80);
        idle(120);
        chk({30'h0, lo}, 32'h0000_0002);
        period <= 8'h04;
        bus(1'b1, 5'h00, 32'h0000_0022);
        wait_fl(0, 200);
        idle(45);
        bus(1'b0, 5'h10, 32'h0);
        chk(q & 32'h0000_001C, 32'h0000_001C);
        // 5 pulses per 20-cycle second, 10000 Hz is full scale: 0.05 %
        chk((q >> 16) & 32'h0000_3FFF, 32'h0000_0005);
    endtask

    // main sequence
    initial begin
        n_mismatch = 0;
        samples_checked = 0;
        cyc = 0;
        nrst_in = 1'b0;
        {rd, wr} = 2'b00;
        addr = 5'h00;
        wdata = 32'h0;
        be = 4'hF;
        level = 14'h1388;
        period = 8'h00;
        idle(4);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        t_regs();
        t_high_err();
        t_high_warn();
        t_low();
        final_report();
    end
endmodule

// File: rtl/fls_cfg.svh
`ifndef FLS_CFG_SVH
`define FLS_CFG_SVH

// ==========================================================
// clock and seconds tick
`define FLS_CLK_HZ 50000000
`define FLS_TICK_PERIOD_S 1
`define FLS_TICK_CYCLES (`FLS_CLK_HZ * `FLS_TICK_PERIOD_S)

// ==========================================================
// flow scaling, hundredths of a percent of full scale
`define FLS_FLOW_W 14
`define FLS_FULL_SCALE 10000
`define FLS_PULSE_FS_HZ 10000
`define FLS_PULSE_CNT_W 16

// ==========================================================
// register byte offsets
`define FLS_OFS_CTRL 5'h00
`define FLS_OFS_HI_LIMIT 5'h04
`define FLS_OFS_LO_LIMIT 5'h08
`define FLS_OFS_TIMES 5'h0C
`define FLS_OFS_STATUS 5'h10
`define FLS_OFS_IRQ_STAT 5'h14
`define FLS_OFS_IRQ_MASK 5'h18

// ==========================================================
// control field positions
`define FLS_CTRL_SRC_LSB 0
`define FLS_CTRL_HI_LSB 2
`define FLS_CTRL_LO_LSB 4
`define FLS_CTRL_CLR_BIT 8

// ==========================================================
// timer field positions
`define FLS_TIMES_HW_LSB 0
`define FLS_TIMES_HS_LSB 8
`define FLS_TIMES_LW_LSB 16
`define FLS_TIMES_LS_LSB 24

// ==========================================================
// status and interrupt bit positions
`define FLS_EV_HI_WARN 0
`define FLS_EV_HI_ERR 1
`define FLS_EV_LO_WARN 2
`define FLS_EV_LO_ERR 3
`define FLS_ST_STOP_BIT 4
`define FLS_ST_FB_LSB 16

// ==========================================================
// reset values
`define FLS_RST_CTRL 6'h00
`define FLS_RST_HI_LIMIT 14'h26AC
`define FLS_RST_LO_LIMIT 14'h0001
`define FLS_RST_TIMES 32'h0000_0000
`define FLS_RST_IRQ_MASK 4'h0

`endif

// File: rtl/fls_pkg.sv
`include "fls_cfg.svh"

package fls_pkg;

    // ======================================================
    // selection codes for a supervised side
    typedef enum logic [1:0] {
        FLS_SEL_OFF = 2'h0,
        FLS_SEL_WARN = 2'h1,
        FLS_SEL_WARN_ERR = 2'h2
    } fls_sel_t;

    // feedback source codes
    typedef enum logic [1:0] {
        FLS_SRC_OFF = 2'h0,
        FLS_SRC_ANALOG = 2'h1,
        FLS_SRC_PULSE = 2'h2
    } fls_src_t;

    // side sequence, gray coded along the usual path
    typedef enum logic [1:0] {
        FLS_ST_IDLE = 2'b00,
        FLS_ST_TIMING = 2'b01,
        FLS_ST_WARNED = 2'b11,
        FLS_ST_STOPPED = 2'b10
    } fls_state_t;

    // configuration of one side
    typedef struct packed {
        logic [1:0] sel;
        logic [7:0] warn_time;
        logic [7:0] stop_time;
    } fls_side_cfg_t;

    // status of one side
    typedef struct packed {
        logic warn;
        logic err;
    } fls_side_sts_t;

endpackage

// File: rtl/fls_side.sv
`timescale 1ns/1ps

module fls_side (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // control
    input wire logic tick_in,
    input wire logic clear_in,
    input wire logic out_of_limit_in,
    input fls_pkg::fls_side_cfg_t cfg_in,
    // status
    output fls_pkg::fls_side_sts_t sts_out
);
    import fls_pkg::*;

    fls_state_t state_ff;
    fls_state_t nxt_state;
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic warn_ff;
    logic err_ff;
    logic enabled;
    logic stop_en;

    // true once the elapsed seconds reach the programmed time
    function automatic logic expired(input logic [7:0] cnt,
                                     input logic [7:0] lim);
        expired = (cnt >= lim);
    endfunction

    // ======================================================
    // sequence control
    assign enabled = (cfg_in.sel == FLS_SEL_WARN) ||
                     (cfg_in.sel == FLS_SEL_WARN_ERR);
    assign stop_en = (cfg_in.sel == FLS_SEL_WARN_ERR);

    // next state and seconds count
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        if (!enabled) begin
            nxt_state = FLS_ST_IDLE;
            nxt_cnt = 8'h00;
        end else begin
            unique case (state_ff)
                FLS_ST_IDLE: begin
                    if (out_of_limit_in) begin
                        nxt_state = FLS_ST_TIMING;
                        nxt_cnt = 8'h00;
                    end
                end
                FLS_ST_TIMING: begin
                    if (!out_of_limit_in) begin
                        nxt_state = FLS_ST_IDLE;
                        nxt_cnt = 8'h00;
                    end else if (expired(cnt_ff, cfg_in.warn_time)) begin
                        nxt_state = FLS_ST_WARNED;
                        nxt_cnt = 8'h00;
                    end else if (tick_in) begin
                        nxt_cnt = cnt_ff + 8'h01;
                    end
                end
                FLS_ST_WARNED: begin
                    if (!out_of_limit_in) begin
                        nxt_state = FLS_ST_IDLE;
                        nxt_cnt = 8'h00;
                    end else if (!stop_en) begin
                        nxt_cnt = 8'h00;
                    end else if (expired(cnt_ff, cfg_in.stop_time)) begin
                        nxt_state = FLS_ST_STOPPED;
                    end else if (tick_in) begin
                        nxt_cnt = cnt_ff + 8'h01;
                    end
                end
                FLS_ST_STOPPED: begin
                    if (clear_in) begin
                        nxt_state = FLS_ST_IDLE;
                        nxt_cnt = 8'h00;
                    end
                end
            endcase
        end
    end

    // state and count registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_ff <= FLS_ST_IDLE;
            cnt_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // registered flags
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            warn_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            warn_ff <= (nxt_state == FLS_ST_WARNED) ||
                       (nxt_state == FLS_ST_STOPPED);
            err_ff <= (nxt_state == FLS_ST_STOPPED);
        end
    end

    assign sts_out.warn = warn_ff;
    assign sts_out.err = err_ff;

    // ======================================================
    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    AST_DISABLED_QUIET: assert property (
        !enabled |=> !warn_ff && !err_ff)
        else $error("disabled side raised a flag");
    AST_WARN_ON_EXPIRY: assert property (
        enabled && state_ff == FLS_ST_TIMING && out_of_limit_in &&
        cnt_ff >= cfg_in.warn_time |=> warn_ff)
        else $error("warning not raised at timer expiry");
    AST_RESTART: assert property (
        enabled && state_ff == FLS_ST_TIMING && !out_of_limit_in
        |=> cnt_ff == 8'h00 && !warn_ff)
        else $error("timer not restarted on return inside limit");
    AST_TICK_STEP: assert property (
        enabled && state_ff == FLS_ST_TIMING && out_of_limit_in &&
        tick_in && cnt_ff < cfg_in.warn_time
        |=> cnt_ff == $past(cnt_ff) + 8'h01)
        else $error("timer did not advance on tick");
    AST_STOP_GATE: assert property (
        $rose(err_ff) |-> $past(stop_en) && $past(warn_ff))
        else $error("stop error without warning plus error mode");
    AST_WARN_ONLY: assert property (
        enabled && !stop_en && state_ff != FLS_ST_STOPPED
        |=> !err_ff)
        else $error("stop error in warning only mode");

    COV_WARN: cover property ($rose(warn_ff));
    COV_ERR: cover property ($rose(err_ff));
    COV_RECOVER: cover property (warn_ff ##1 !warn_ff && !err_ff);

endmodule

// File: rtl/fls_top.sv
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`include "fls_cfg.svh"

// Operation
// - above high limit, count high warning timer
// - back inside restarts; expiry raises high warning
// - warned and still high counts stop timer
// - high stop expiry raises error, stops drive
// - high select: off, warning, warning plus error
// - high limit is hundredths percent of full
// - below low limit, count low warning timer
// - back inside restarts; expiry raises low warning
// - warned and still low counts stop timer
// - low stop expiry raises error, stops drive
// - low limit is hundredths percent of full
// - low select zero silences low supervision
// - source: off, analog input, pulse input
// - low select: warning, or warning plus error
module fls_top #(
    parameter int TICK_CYCLES = `FLS_TICK_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // avalon-mm slave
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // flow meter pins
    input wire logic [13:0] analog_flow_input_in,
    input wire logic pulse_flow_input_in,
    // drive control
    output logic stop_request_out,
    output fls_pkg::fls_side_sts_t high_flow_out,
    output fls_pkg::fls_side_sts_t low_flow_out,
    output logic irq_out
);
    import fls_pkg::*;

    // scale a one second pulse count to hundredths of a percent
    function automatic logic [13:0] pulse_to_pct(
        input logic [15:0] cnt);
        logic [31:0] prod;
        prod = {16'h0000, cnt} * 32'd`FLS_FULL_SCALE
               / 32'd`FLS_PULSE_FS_HZ;
        pulse_to_pct = (prod > 32'd`FLS_FULL_SCALE) ?
            14'(`FLS_FULL_SCALE) : prod[13:0];
    endfunction

    // merge one written byte lane set into a register word
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        lane_merge = res;
    endfunction

    // ======================================================
    // pin synchronisers
    logic [13:0] ana_meta_ff;
    logic [13:0] ana_sync_ff;
    logic pul_meta_ff;
    logic pul_sync_ff;
    logic pul_prev_ff;

    // two flops on every pin, edge detect on the second
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ana_meta_ff <= 14'h0000;
            ana_sync_ff <= 14'h0000;
            pul_meta_ff <= 1'b0;
            pul_sync_ff <= 1'b0;
            pul_prev_ff <= 1'b0;
        end else begin
            ana_meta_ff <= analog_flow_input_in;
            ana_sync_ff <= ana_meta_ff;
            pul_meta_ff <= pulse_flow_input_in;
            pul_sync_ff <= pul_meta_ff;
            pul_prev_ff <= pul_sync_ff;
        end
    end

    // ======================================================
    // seconds tick divider
    logic [31:0] div_ff;
    logic tick_ff;

    // one-cycle enable once per second
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (div_ff >= 32'(TICK_CYCLES - 1)) begin
            div_ff <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    // ======================================================
    // pulse rate measurement over one second
    logic [15:0] pul_cnt_ff;
    logic [13:0] pul_pct_ff;
    logic pul_edge;
    // an edge in the tick cycle opens the next window, none is lost
    assign pul_edge = pul_sync_ff && !pul_prev_ff;

    // count rising edges, latch scaled rate at each tick
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pul_cnt_ff <= 16'h0000;
            pul_pct_ff <= 14'h0000;
        end else if (tick_ff) begin
            pul_cnt_ff <= {15'h0000, pul_edge};
            pul_pct_ff <= pulse_to_pct(pul_cnt_ff);
        end else if (pul_edge && pul_cnt_ff != 16'hFFFF) begin
            pul_cnt_ff <= pul_cnt_ff + 16'h0001;
        end
    end

    // ======================================================
    // registers
    logic [5:0] ctrl_ff;
    logic [13:0] hi_lim_ff;
    logic [13:0] lo_lim_ff;
    logic [31:0] times_ff;
    logic [3:0] irq_stat_ff;
    logic [3:0] irq_mask_ff;
    logic [31:0] rdata_ff;
    logic done_ff;
    logic req;
    logic wr_en;
    logic clr_pulse;
    logic [31:0] wr_word;

    // ======================================================
    // feedback selection and limit compare
    logic [13:0] fb;
    logic fb_valid;
    logic hi_ool;
    logic lo_ool;
    fls_side_cfg_t hi_cfg;
    fls_side_cfg_t lo_cfg;
    fls_side_sts_t hi_sts;
    fls_side_sts_t lo_sts;
    fls_side_sts_t hi_prev_ff;
    fls_side_sts_t lo_prev_ff;

    // source mux, disabled source supervises nothing
    always_comb begin
        fb = 14'h0000;
        fb_valid = 1'b0;
        unique case (ctrl_ff[`FLS_CTRL_SRC_LSB +: 2])
            FLS_SRC_ANALOG: begin
                fb = ana_sync_ff;
                fb_valid = 1'b1;
            end
            FLS_SRC_PULSE: begin
                fb = pul_pct_ff;
                fb_valid = 1'b1;
            end
            default: begin
                fb = 14'h0000;
                fb_valid = 1'b0;
            end
        endcase
    end

    assign hi_ool = fb_valid && (fb > hi_lim_ff);
    assign lo_ool = fb_valid && (fb < lo_lim_ff);

    // side configuration
    assign hi_cfg.sel = ctrl_ff[`FLS_CTRL_HI_LSB +: 2];
    assign hi_cfg.warn_time = times_ff[`FLS_TIMES_HW_LSB +: 8];
    assign hi_cfg.stop_time = times_ff[`FLS_TIMES_HS_LSB +: 8];
    assign lo_cfg.sel = ctrl_ff[`FLS_CTRL_LO_LSB +: 2];
    assign lo_cfg.warn_time = times_ff[`FLS_TIMES_LW_LSB +: 8];
    assign lo_cfg.stop_time = times_ff[`FLS_TIMES_LS_LSB +: 8];

    // high side supervision
    fls_side u_high (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .tick_in(tick_ff),
        .clear_in(clr_pulse),
        .out_of_limit_in(hi_ool),
        .cfg_in(hi_cfg),
        .sts_out(hi_sts)
    );

    // low side supervision
    fls_side u_low (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .tick_in(tick_ff),
        .clear_in(clr_pulse),
        .out_of_limit_in(lo_ool),
        .cfg_in(lo_cfg),
        .sts_out(lo_sts)
    );

    // flags and stop command, all from flops
    assign high_flow_out = hi_sts;
    assign low_flow_out = lo_sts;

    // stop command registered
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stop_request_out <= 1'b0;
        end else begin
            stop_request_out <= hi_sts.err || lo_sts.err;
        end
    end

    // ======================================================
    // avalon handshake: one wait cycle per access
    assign req = avs_read_in || avs_write_in;
    assign avs_waitrequest_out = req && !done_ff;
    assign wr_en = avs_write_in && done_ff;
    assign clr_pulse = wr_en && (avs_address_in == `FLS_OFS_CTRL) &&
                       avs_byteenable_in[1] &&
                       avs_writedata_in[`FLS_CTRL_CLR_BIT];
    assign avs_readdata_out = rdata_ff;
    assign wr_word = lane_merge( // addressed word, written lanes merged
        (avs_address_in == `FLS_OFS_CTRL) ? {26'h000_0000, ctrl_ff} :
        (avs_address_in == `FLS_OFS_HI_LIMIT) ? {18'h0_0000, hi_lim_ff} :
        (avs_address_in == `FLS_OFS_LO_LIMIT) ? {18'h0_0000, lo_lim_ff} :
        times_ff, avs_writedata_in, avs_byteenable_in);

    // done marks the accepting cycle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= req && !done_ff;
        end
    end

    // read data captured in the wait cycle, zero when unmapped
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_ff <= 32'h0000_0000;
        end else if (avs_read_in && !done_ff) begin
            unique case (avs_address_in)
                `FLS_OFS_CTRL: rdata_ff <= {26'h000_0000, ctrl_ff};
                `FLS_OFS_HI_LIMIT: rdata_ff <= {18'h0_0000, hi_lim_ff};
                `FLS_OFS_LO_LIMIT: rdata_ff <= {18'h0_0000, lo_lim_ff};
                `FLS_OFS_TIMES: rdata_ff <= times_ff;
                `FLS_OFS_STATUS: rdata_ff <= {2'b00, fb, 11'h000,
                    stop_request_out, lo_sts.err, lo_sts.warn,
                    hi_sts.err, hi_sts.warn};
                `FLS_OFS_IRQ_STAT: rdata_ff <= {28'h000_0000, irq_stat_ff};
                `FLS_OFS_IRQ_MASK: rdata_ff <= {28'h000_0000, irq_mask_ff};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // configuration registers written on the accepting edge
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_ff <= `FLS_RST_CTRL;
            hi_lim_ff <= `FLS_RST_HI_LIMIT;
            lo_lim_ff <= `FLS_RST_LO_LIMIT;
            times_ff <= `FLS_RST_TIMES;
            irq_mask_ff <= `FLS_RST_IRQ_MASK;
        end else if (wr_en) begin
            unique case (avs_address_in)
                `FLS_OFS_CTRL: ctrl_ff <= wr_word[5:0];
                `FLS_OFS_HI_LIMIT: hi_lim_ff <= wr_word[13:0];
                `FLS_OFS_LO_LIMIT: lo_lim_ff <= wr_word[13:0];
                `FLS_OFS_TIMES: times_ff <= wr_word;
                `FLS_OFS_IRQ_MASK: if (avs_byteenable_in[0]) begin
                    irq_mask_ff <= avs_writedata_in[3:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ======================================================
    // interrupts: rising flags set sticky bits, write one clears
    logic [3:0] ev_set;
    logic [3:0] ev_clr;

    assign ev_set = {lo_sts.err && !lo_prev_ff.err,
                     lo_sts.warn && !lo_prev_ff.warn,
                     hi_sts.err && !hi_prev_ff.err,
                     hi_sts.warn && !hi_prev_ff.warn};
    assign ev_clr = (wr_en && avs_address_in == `FLS_OFS_IRQ_STAT &&
                     avs_byteenable_in[0]) ? avs_writedata_in[3:0] :
                    4'h0;

    // previous flags for edge detection
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hi_prev_ff <= '0;
            lo_prev_ff <= '0;
        end else begin
            hi_prev_ff <= hi_sts;
            lo_prev_ff <= lo_sts;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_stat_ff <= 4'h0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~ev_clr) | ev_set;
        end
    end

    assign irq_out = |(irq_stat_ff & irq_mask_ff);

    // ======================================================
    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    AST_HI_COMPARE: assert property (
        fb_valid && fb > hi_lim_ff |-> hi_ool && !lo_ool ||
        lo_lim_ff > fb)
        else $error("high compare wrong");
    AST_SRC_OFF: assert property (
        ctrl_ff[`FLS_CTRL_SRC_LSB +: 2] == FLS_SRC_OFF |->
        !hi_ool && !lo_ool)
        else $error("disabled source still supervised");
    AST_STOP_FOLLOWS: assert property (
        $rose(hi_sts.err) |=> stop_request_out)
        else $error("high stop error did not stop the drive");
    AST_LO_STOP: assert property (
        $rose(lo_sts.err) |=> stop_request_out)
        else $error("low stop error did not stop the drive");
    AST_WAIT_ONE: assert property (
        req && !done_ff && $stable(avs_address_in)
        |-> avs_waitrequest_out ##1 (!avs_waitrequest_out || !req))
        else $error("access not answered after one wait cycle");
    AST_IRQ_STICKY: assert property (
        $rose(hi_sts.warn) |=> irq_stat_ff[`FLS_EV_HI_WARN])
        else $error("high warning event not recorded");

    COV_HI_STOP: cover property ($rose(hi_sts.err));
    COV_LO_STOP: cover property ($rose(lo_sts.err));
    COV_IRQ: cover property ($rose(irq_out));

endmodule
